// file: design/acct_map.svh
// Constants of the converter control block: codes, reset values, timing counts
`ifndef ACCT_MAP_SVH
`define ACCT_MAP_SVH

// ==========================================================================
// Input selector codes
// ==========================================================================
`define ACCT_SEL_EXT_LAST 5'h0f
`define ACCT_SEL_TEMP 5'h1a
`define ACCT_SEL_BANDGAP 5'h1b
`define ACCT_SEL_RESV 5'h1c
`define ACCT_SEL_REF_HIGH 5'h1d
`define ACCT_SEL_REF_LOW 5'h1e
`define ACCT_SEL_OFF 5'h1f

// ==========================================================================
// Clock source and result format codes
// ==========================================================================
`define ACCT_CLK_BUS 2'h0
`define ACCT_CLK_BUS_HALF 2'h1
`define ACCT_CLK_ALT 2'h2
`define ACCT_CLK_LOCAL 2'h3
`define ACCT_FMT_8 2'h0
`define ACCT_FMT_12 2'h1
`define ACCT_FMT_10 2'h2

// ==========================================================================
// Reset values and timing
// ==========================================================================
`define ACCT_RESULT_RST 12'h000
`define ACCT_CHAN_COUNT 28
`define ACCT_RES_BITS 12
`define ACCT_LOCAL_DIV 4
`define ACCT_SAMPLE_SHORT 4
`define ACCT_SAMPLE_LONG 24

`endif

// file: design/acct_pkg.sv
// Types of the converter control block
package acct_pkg;

    // ======================================================================
    // Configuration carried from the control ports
    // ======================================================================
    typedef struct packed {
        logic [4:0] input_select_field;
        logic [1:0] clk_source;
        logic [1:0] clock_divide_field;
        logic [1:0] result_format;
        logic continuous;
        logic trigger_select_bit;
        logic long_sample;
        logic compare_function_enable;
        logic compare_greater_equal;
    } acct_cfg_t;

    // ======================================================================
    // Power state of the device
    // ======================================================================
    typedef enum logic [1:0] {
        ACCT_PWR_RUN = 2'h0,
        ACCT_PWR_WAIT = 2'h1,
        ACCT_PWR_STOP3 = 2'h2,
        ACCT_PWR_STOP2 = 2'h3
    } acct_pwr_t;

    // ======================================================================
    // Converter sequence states
    // ======================================================================
    typedef enum logic [3:0] {
        ACCT_ST_IDLE = 4'b0001,
        ACCT_ST_SAMPLE = 4'b0010,
        ACCT_ST_APPROX = 4'b0100,
        ACCT_ST_DONE = 4'b1000
    } acct_state_t;

endpackage : acct_pkg

// file: design/acct_sync_pulse.sv
// Two-flop synchroniser with rising-edge pulse output
`timescale 1ns/1ps
`include "acct_map.svh"

module acct_sync_pulse (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Asynchronous level in, one-cycle pulse out
    input wire logic async_i,
    output logic pulse_o
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic last_q, last_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
        last_d = sync_q;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    // One pulse per rising edge of the input level
    assign pulse_o = sync_q & ~last_q;
endmodule : acct_sync_pulse

// file: design/acct_ctrl.sv
// Converter control: input select, clock choice, triggering, approximation, compare
`timescale 1ns/1ps
`include "acct_map.svh"

//Contract
// - Decode selector onto channels, sensors, references, off
// - Reserved codes still convert, result undefined
// - Absent channel bits treated as reserved
// - Conversion clock from four selectable sources
// - Alternate clock keeps running in wait
// - Alternate clock unusable in both stop modes
// - Counter overflow starts a conversion when enabled, repeating if continuous
// - Hardware trigger works in run, wait, stop3
// - Twelve-bit linear successive approximation
// - Right-justified results in 12, 10, 8 bits
// - Single and continuous; single returns idle
// - Compare less-than or greater-equal, may interrupt
// - Done flag with interrupt request
// - Up to 16 external analog inputs
// - Control write aborts; restarts with software trigger unless off
// - Trigger select chooses software or hardware start
// - All-ones selector powers down, no extra conversion
module acct_ctrl #(
    parameter int CHAN_PRESENT = 16,
    parameter int RES_BITS = `ACCT_RES_BITS
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Configuration and control
    input wire acct_pkg::acct_cfg_t cfg_i,
    input wire logic ctrl_write_i,
    input wire logic result_read_i,
    input wire logic [11:0] compare_value_i,
    input wire acct_pkg::acct_pwr_t power_mode_i,
    input wire logic interrupt_enable_i,
    // Clock sources and trigger
    input wire logic local_clk_tick_i,
    input wire logic alternate_conv_clock_i,
    input wire logic hw_conv_trigger_i,
    // Analog front end
    input wire logic comparator_i,
    output logic [4:0] mux_select_o,
    output logic [27:0] chan_enable_o,
    output logic temp_enable_o,
    output logic bandgap_enable_o,
    output logic ref_high_enable_o,
    output logic ref_low_enable_o,
    output logic [11:0] dac_code_o,
    output logic analog_power_o,
    output logic sample_o,
    // Status
    output logic [11:0] result_o,
    output logic conversion_done_flag_o,
    output logic active_o,
    output logic reserved_select_o,
    output logic irq_o
);
    import acct_pkg::*;

    // Refuse widths and channel counts that the decode cannot serve
    if (RES_BITS != 12 || CHAN_PRESENT < 1 || CHAN_PRESENT > 16) begin : g_param_check
        $error("acct_ctrl: unsupported parameters");
    end

    // ======================================================================
    // Input selector decode
    // ======================================================================
    function automatic logic sel_is_reserved(input logic [4:0] sel);
        logic res;
        res = 1'b0;
        if (sel <= `ACCT_SEL_EXT_LAST) begin
            res = (32'(sel) >= CHAN_PRESENT);
        end else if (sel < `ACCT_SEL_TEMP || sel == `ACCT_SEL_RESV) begin
            res = 1'b1;
        end
        return res;
    endfunction : sel_is_reserved

    logic [4:0] sel;
    logic sel_off;
    assign sel = cfg_i.input_select_field;
    assign sel_off = (sel == `ACCT_SEL_OFF);

    always_comb begin
        chan_enable_o = 28'h0000000;
        if (!sel_off && sel < 5'(`ACCT_CHAN_COUNT) && !sel_is_reserved(sel)) begin
            chan_enable_o[sel] = 1'b1;
        end
    end
    assign mux_select_o = sel;
    assign temp_enable_o = (sel == `ACCT_SEL_TEMP);
    assign bandgap_enable_o = (sel == `ACCT_SEL_BANDGAP);
    assign ref_high_enable_o = (sel == `ACCT_SEL_REF_HIGH);
    assign ref_low_enable_o = (sel == `ACCT_SEL_REF_LOW);
    assign reserved_select_o = sel_is_reserved(sel);

    // ======================================================================
    // Conversion clock enable
    // ======================================================================
    logic alt_tick;
    logic half_q, half_d;
    logic src_tick;
    logic alt_ok;
    logic [2:0] div_cnt_q, div_cnt_d;
    logic [2:0] div_last;
    logic conv_tick;

    acct_sync_pulse u_alt_sync (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .async_i(alternate_conv_clock_i),
        .pulse_o(alt_tick)
    );

    // Alternate clock runs in run and wait, never in stop modes
    assign alt_ok = (power_mode_i == ACCT_PWR_RUN) || (power_mode_i == ACCT_PWR_WAIT);

    always_comb begin
        half_d = ~half_q;
        unique case (cfg_i.clk_source)
            `ACCT_CLK_BUS: src_tick = 1'b1;
            `ACCT_CLK_BUS_HALF: src_tick = half_q;
            `ACCT_CLK_ALT: src_tick = alt_tick & alt_ok;
            `ACCT_CLK_LOCAL: src_tick = local_clk_tick_i;
        endcase
        div_last = 3'((1 << cfg_i.clock_divide_field) - 1);
        div_cnt_d = div_cnt_q;
        conv_tick = 1'b0;
        if (src_tick) begin
            if (div_cnt_q >= div_last) begin
                div_cnt_d = 3'h0;
                conv_tick = 1'b1;
            end else begin
                div_cnt_d = div_cnt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            half_q <= 1'b0;
            div_cnt_q <= 3'h0;
        end else begin
            half_q <= half_d;
            div_cnt_q <= div_cnt_d;
        end
    end

    // ======================================================================
    // Hardware trigger
    // ======================================================================
    logic hw_pulse;
    acct_sync_pulse u_trig_sync (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .async_i(hw_conv_trigger_i),
        .pulse_o(hw_pulse)
    );

    // Stop2 powers the counter trigger path down
    logic hw_start;
    assign hw_start = hw_pulse && cfg_i.trigger_select_bit && !sel_off
        && power_mode_i != ACCT_PWR_STOP2;

    // ======================================================================
    // Approximation sequencer
    // ======================================================================
    acct_state_t state_q, state_d;
    logic [4:0] cnt_q, cnt_d;
    logic [11:0] sar_q, sar_d;
    logic [11:0] result_q, result_d;
    logic done_q, done_d;
    logic armed_q, armed_d;
    logic [4:0] sample_len;
    logic [11:0] trial_bit;
    logic [11:0] formatted;
    logic cmp_true;

    assign sample_len = cfg_i.long_sample ? 5'(`ACCT_SAMPLE_LONG) : 5'(`ACCT_SAMPLE_SHORT);
    assign trial_bit = 12'h800 >> cnt_q[3:0];

    always_comb begin
        unique case (cfg_i.result_format)
            `ACCT_FMT_8: formatted = {4'h0, sar_q[11:4]};
            `ACCT_FMT_10: formatted = {2'h0, sar_q[11:2]};
            default: formatted = sar_q;
        endcase
        if (cfg_i.compare_greater_equal) begin
            cmp_true = (formatted >= compare_value_i);
        end else begin
            cmp_true = (formatted < compare_value_i);
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        sar_d = sar_q;
        result_d = result_q;
        done_d = done_q;
        armed_d = armed_q;
        if (result_read_i) begin
            done_d = 1'b0;
        end
        unique case (state_q)
            ACCT_ST_IDLE: begin
                if (hw_start) begin
                    armed_d = cfg_i.continuous;
                    state_d = ACCT_ST_SAMPLE;
                    cnt_d = 5'h00;
                end else if (armed_q && !sel_off) begin
                    state_d = ACCT_ST_SAMPLE;
                    cnt_d = 5'h00;
                end
            end
            ACCT_ST_SAMPLE: begin
                if (conv_tick) begin
                    if (cnt_q + 5'h01 >= sample_len) begin
                        state_d = ACCT_ST_APPROX;
                        cnt_d = 5'h00;
                        sar_d = 12'h800;
                    end else begin
                        cnt_d = cnt_q + 5'h01;
                    end
                end
            end
            ACCT_ST_APPROX: begin
                if (conv_tick) begin
                    // Keep the trial bit when the input is above the DAC level
                    sar_d = comparator_i ? sar_q : (sar_q & ~trial_bit);
                    if (cnt_q == 5'(RES_BITS - 1)) begin
                        state_d = ACCT_ST_DONE;
                    end else begin
                        sar_d = sar_d | (trial_bit >> 1);
                        cnt_d = cnt_q + 5'h01;
                    end
                end
            end
            ACCT_ST_DONE: begin
                if (!cfg_i.compare_function_enable || cmp_true) begin
                    result_d = formatted;
                    done_d = 1'b1;
                end
                // Single mode drops back to idle by itself
                if (!cfg_i.continuous) begin
                    armed_d = 1'b0;
                end
                state_d = ACCT_ST_IDLE;
            end
            default: state_d = ACCT_ST_IDLE;
        endcase
        // A control write outranks every transition chosen above
        if (ctrl_write_i) begin
            done_d = 1'b0;
            state_d = ACCT_ST_IDLE;
            armed_d = !sel_off && (!cfg_i.trigger_select_bit || armed_q);
            if (sel_off) begin
                armed_d = 1'b0;
            end else if (cfg_i.trigger_select_bit) begin
                armed_d = 1'b0;
            end
        end else if (sel_off) begin
            state_d = ACCT_ST_IDLE;
            armed_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state_q <= ACCT_ST_IDLE;
            cnt_q <= 5'h00;
            sar_q <= 12'h000;
            result_q <= `ACCT_RESULT_RST;
            done_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sar_q <= sar_d;
            result_q <= result_d;
            done_q <= done_d;
            armed_q <= armed_d;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign active_o = (state_q != ACCT_ST_IDLE);
    assign analog_power_o = active_o && !sel_off;
    assign sample_o = (state_q == ACCT_ST_SAMPLE);
    assign dac_code_o = sar_q;
    assign result_o = result_q;
    assign conversion_done_flag_o = done_q;
    assign irq_o = done_q & interrupt_enable_i;
endmodule : acct_ctrl

// file: testbench/acct_ctrl_asserts.sv
// Port checks for the converter control block
`timescale 1ns/1ps
`include "acct_map.svh"
module acct_ctrl_asserts #(
    parameter int CHAN_PRESENT = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Inputs
    input wire acct_pkg::acct_cfg_t cfg_i,
    input wire logic ctrl_write_i,
    input wire logic result_read_i,
    input wire acct_pkg::acct_pwr_t power_mode_i,
    input wire logic interrupt_enable_i,
    // Outputs
    input wire logic [4:0] mux_select_o,
    input wire logic sample_o,
    input wire logic [11:0] dac_code_o,
    input wire logic [11:0] result_o,
    input wire logic conversion_done_flag_o,
    input wire logic active_o,
    input wire logic reserved_select_o,
    input wire logic irq_o
);
    import acct_pkg::*;
    logic [4:0] sel;
    logic [1:0] fmt;
    assign sel = cfg_i.input_select_field;
    assign fmt = cfg_i.result_format;
    // ==========
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    sequence sw_arm;
        ctrl_write_i && !cfg_i.trigger_select_bit && sel != `ACCT_SEL_OFF
            && cfg_i.clk_source == `ACCT_CLK_BUS && cfg_i.clock_divide_field == 2'h0
            && power_mode_i == ACCT_PWR_RUN;
    endsequence
    sequence sampling;
        active_o && sample_o;
    endsequence
    mux_route_a: assert property (mux_select_o == sel)
        else $error("selector not routed");
    resv_decode_a: assert property (reserved_select_o == ((sel > 5'h0f && sel < 5'h1a)
        || sel == `ACCT_SEL_RESV || (sel <= 5'h0f && sel >= CHAN_PRESENT)))
        else $error("reserved decode wrong");
    irq_out_a: assert property (irq_o == (conversion_done_flag_o && interrupt_enable_i))
        else $error("irq wrong");
    sw_start_a: assert property (sw_arm |-> ##2 sampling)
        else $error("write did not start");
    off_stop_a: assert property (ctrl_write_i && sel == `ACCT_SEL_OFF |=> !active_o)
        else $error("off did not stop");
    sar_msb_a: assert property ($fell(sample_o) && active_o |-> dac_code_o == 12'h800)
        else $error("first trial wrong");
    single_idle_a: assert property ($rose(conversion_done_flag_o) && !cfg_i.continuous
        |-> !active_o) else $error("single not idle");
    fmt_width_a: assert property ($rose(conversion_done_flag_o) |-> (fmt == `ACCT_FMT_8
        ? result_o[11:8] == 4'h0 : fmt == `ACCT_FMT_10 ? result_o[11:10] == 2'h0 : 1'b1))
        else $error("result too wide");
    read_clear_a: assert property (result_read_i && !active_o |=> !conversion_done_flag_o)
        else $error("read kept done");
    stop2_hold_a: assert property (power_mode_i == ACCT_PWR_STOP2 && !active_o
        && !ctrl_write_i && !$past(ctrl_write_i) && !cfg_i.continuous |=> !active_o)
        else $error("started in stop2");
endmodule : acct_ctrl_asserts

bind acct_ctrl acct_ctrl_asserts #(.CHAN_PRESENT(CHAN_PRESENT)) u_chk (.clk_sys_i,
    .reset_n_i, .cfg_i, .ctrl_write_i, .result_read_i, .power_mode_i, .interrupt_enable_i,
    .mux_select_o, .sample_o, .dac_code_o, .result_o, .conversion_done_flag_o, .active_o,
    .reserved_select_o, .irq_o);

// file: testbench/acct_front_model.sv
// Far side: analog level behind the comparator, counter overflow output
`timescale 1ns/1ps
module acct_front_model (
    // Clock
    input wire logic clk_sys_i,
    // Analog side
    input wire logic [11:0] level_i,
    input wire logic [11:0] dac_code_i,
    output logic comparator_o,
    // Counter side
    input wire logic ovf_i,
    output logic trig_o
);
    int hold = 0;
    assign comparator_o = level_i >= dac_code_i;
    // Each overflow gives one rising edge held a few cycles
    assign trig_o = hold != 0;
    always @(posedge clk_sys_i) begin
        if (ovf_i) hold <= 6;
        else if (hold > 0) hold <= hold - 1;
    end
endmodule : acct_front_model

// file: testbench/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "acct_map.svh"
module testbench;
    import acct_pkg::*;
    logic clk_sys_i = 0, reset_n_i = 0, ctrl_write_i = 0, result_read_i = 0;
    logic interrupt_enable_i = 1, local_clk_tick_i = 0, alternate_conv_clock_i = 0, ovf = 0;
    acct_cfg_t cfg_i = '0;
    acct_pwr_t power_mode_i = ACCT_PWR_RUN;
    logic hw_conv_trigger_i, comparator_i, temp_enable_o, bandgap_enable_o, sample_o;
    logic ref_high_enable_o, ref_low_enable_o, analog_power_o, irq_o;
    logic conversion_done_flag_o, active_o, reserved_select_o;
    logic [4:0] mux_select_o;
    logic [27:0] chan_enable_o;
    logic [11:0] dac_code_o, result_o, compare_value_i = '0, lvl = '0;
    int n_fail = 0, tests_run = 0, cyc = 0, rate = 2, q[$];
    acct_ctrl dut (.clk_sys_i, .reset_n_i, .cfg_i, .ctrl_write_i, .result_read_i,
        .compare_value_i, .power_mode_i, .interrupt_enable_i, .local_clk_tick_i,
        .alternate_conv_clock_i, .hw_conv_trigger_i, .comparator_i, .mux_select_o,
        .chan_enable_o, .temp_enable_o, .bandgap_enable_o, .ref_high_enable_o,
        .ref_low_enable_o, .dac_code_o, .analog_power_o, .sample_o, .result_o,
        .conversion_done_flag_o, .active_o, .reserved_select_o, .irq_o);
    acct_front_model u_far (.clk_sys_i, .level_i(lvl), .dac_code_i(dac_code_o),
        .comparator_o(comparator_i), .ovf_i(ovf), .trig_o(hw_conv_trigger_i));
    // ==========
    // Clocks and limit
    initial forever #10 clk_sys_i = ~clk_sys_i;
    always #13 alternate_conv_clock_i = ~alternate_conv_clock_i;
    always @(posedge clk_sys_i) begin
        local_clk_tick_i <= #1 ($urandom % rate) == 0;
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail++;
            close_out;
        end
    end
    // ==========
    // Tasks
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : step
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        s = 1;
        step(1);
        s = 0;
    endtask : pulse
    task automatic quiet(input int n);
        step(n);
        chk(conversion_done_flag_o, 0);
    endtask : quiet
    task automatic fin(input int l);
        for (int i = 0; i < 20000 && conversion_done_flag_o !== 1'b1; i++)
            step(1);
        chk(conversion_done_flag_o, 1);
        chk(irq_o, interrupt_enable_i);
        if (!cfg_i.continuous) chk(active_o, 0);
        q.push_back(cfg_i.result_format == `ACCT_FMT_8 ? l >> 4
            : cfg_i.result_format == `ACCT_FMT_10 ? l >> 2 : l);
        chk(result_o, q.pop_front());
        pulse(result_read_i);
        chk(conversion_done_flag_o, 0);
    endtask : fin
    task automatic conv(input int s, input int c, input int l);
        cfg_i.input_select_field = s[4:0];
        cfg_i.clk_source = c[1:0];
        lvl = l[11:0];
        pulse(ctrl_write_i);
        fin(l);
    endtask : conv
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    // ==========
    // Scenarios
    initial begin
        void'($urandom(32'hab0bf42c));
        step(20);
        chk({result_o, dac_code_o, conversion_done_flag_o, irq_o}, 0);
        reset_n_i = 1;
        for (int s = 0; s < 32; s++) begin
            cfg_i.input_select_field = s[4:0];
            step(1);
            chk(mux_select_o, s);
            chk({temp_enable_o, bandgap_enable_o}, {s == 26, s == 27});
            chk({ref_high_enable_o, ref_low_enable_o}, {s == 29, s == 30});
            chk(reserved_select_o, (s > 15 && s < 26) || s == 28);
            chk(chan_enable_o, (s < 16 || s == 26 || s == 27) ? 32'h1 << s : 32'h0);
        end
        for (int c = 0; c < 4; c++) begin
            for (int f = 0; f < 3; f++) begin
                power_mode_i = c == `ACCT_CLK_ALT ? ACCT_PWR_WAIT : ACCT_PWR_RUN;
                cfg_i.result_format = f[1:0];
                cfg_i.clock_divide_field = 2'($urandom);
                interrupt_enable_i = f[0];
                conv($urandom % 16, c, $urandom % 4096);
            end
        end
        power_mode_i = ACCT_PWR_RUN;
        cfg_i.clock_divide_field = 2'h0;
        pulse(ctrl_write_i);
        step(8);
        cfg_i.result_format = `ACCT_FMT_8;
        conv(3, 0, 12'h9c4);
        cfg_i.result_format = `ACCT_FMT_12;
        cfg_i.compare_function_enable = 1;
        compare_value_i = 12'h7ff;
        cfg_i.compare_greater_equal = 1;
        conv(5, 0, 12'h7ff);
        cfg_i.compare_greater_equal = 0;
        pulse(ctrl_write_i);
        quiet(300);
        chk(result_o, 12'h7ff);
        conv(5, 0, 12'h7fe);
        cfg_i.compare_function_enable = 0;
        cfg_i.input_select_field = `ACCT_SEL_RESV;
        pulse(ctrl_write_i);
        step(60);
        chk(conversion_done_flag_o, 1);
        pulse(result_read_i);
        cfg_i.long_sample = 1;
        rate = 60;
        conv(`ACCT_SEL_BANDGAP, `ACCT_CLK_LOCAL, 12'h5d2);
        conv(`ACCT_SEL_TEMP, `ACCT_CLK_LOCAL, 12'h3a1);
        rate = 2;
        cfg_i.long_sample = 0;
        cfg_i.clk_source = `ACCT_CLK_ALT;
        power_mode_i = ACCT_PWR_STOP3;
        pulse(ctrl_write_i);
        quiet(2000);
        chk({active_o, analog_power_o, sample_o}, 3'b111);
        cfg_i.input_select_field = `ACCT_SEL_OFF;
        pulse(ctrl_write_i);
        chk({active_o, analog_power_o}, 0);
        power_mode_i = ACCT_PWR_RUN;
        cfg_i.continuous = 1;
        conv(7, 0, 12'h123);
        fin(12'h123);
        cfg_i.input_select_field = `ACCT_SEL_OFF;
        pulse(ctrl_write_i);
        quiet(200);
        chk(active_o, 0);
        cfg_i.continuous = 0;
        cfg_i.trigger_select_bit = 1;
        cfg_i.input_select_field = 5'h02;
        cfg_i.clk_source = `ACCT_CLK_LOCAL;
        for (int m = 0; m < 4; m++) begin
            power_mode_i = acct_pwr_t'(m);
            lvl = 12'($urandom);
            pulse(ovf);
            step(10);
            pulse(ovf);
            if (m == 3) quiet(400);
            else fin(lvl);
            quiet(300);
        end
        power_mode_i = ACCT_PWR_RUN;
        cfg_i.trigger_select_bit = 0;
        pulse(ovf);
        quiet(300);
        close_out;
    end
endmodule : testbench
